// file: design/css_clock_startup.sv
/*
  Clock source decode, start-up sequencing and oscillator trim register.
  Assumes static fuse levels, free-running watchdog and oscillator inputs
  from other domains, and an AXI4-Lite master on the system clock.
*/
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
// Overview of operation
// - Source-select fuses 0100 to 0111 choose the low-frequency watch crystal.
// - Internal load capacitors on both crystal pins enabled only for codes 0110, 0111.
// - Low-frequency crystal reset delay: 00 none, 01 4.1 ms, 10 65 ms, 11 reserved.
// - Low-frequency wake start-up: 1K cycles for low bits 00/10, 32K for 01/11.
// - Code 0010 selects the 8 MHz internal RC oscillator, no external parts.
// - Delivered fuses: source 0010, start-up 10, divide-by-eight programmed.
// - RC oscillator: 6 cycle wake; reset delay none, 4.1 ms, 65 ms; 11 reserved.
// - Every reset loads the factory calibration byte into the trim register.
// - Watchdog oscillator always times the reset time-out, whatever the source.
// - Trim register bit 7 is reserved and always reads zero.
// - Seven-bit trim raises RC frequency monotonically, zero lowest, 0x7F highest.
// - Fuse bits read one as unprogrammed and zero as programmed.
// - Prescaler field resets to 0011 if divide-by-eight programmed, else 0000.
`timescale 1ns/1ns
module css_clock_startup
  import css_pkg::*;
#(
  parameter int RST_SHORT_WDT = CSS_RST_SHORT_WDT,
  parameter int RST_LONG_WDT = CSS_RST_LONG_WDT,
  parameter int LF_LONG_CK = CSS_LF_LONG_CK
) (
  input wire logic clock,  // 50 MHz system clock
  input wire logic rst_n,  // synchronous reset, active low
  input wire logic [3:0] clockSourceSelectFuses,  // source select fuses
  input wire logic [1:0] startupTimeFuses,  // start-up time fuses
  input wire logic divideByEightFuse,  // zero when programmed
  input wire logic fuseArrayBlank,  // fuses still as delivered
  input wire logic [7:0] factoryCal,  // stored calibration byte
  input wire logic wdtOscIn,  // watchdog oscillator level
  input wire logic oscCycleIn,  // selected oscillator level
  input wire logic sleepRequest,  // enter power-down or power-save
  input wire logic wakeRequest,  // wake from sleep
  input wire logic [CSS_AW-1:0] s_axi_awaddr,  // write address
  input wire logic s_axi_awvalid,  // write address valid
  output logic s_axi_awready,  // write address ready
  input wire logic [31:0] s_axi_wdata,  // write data
  input wire logic [3:0] s_axi_wstrb,  // write strobes
  input wire logic s_axi_wvalid,  // write data valid
  output logic s_axi_wready,  // write data ready
  output logic [1:0] s_axi_bresp,  // write response
  output logic s_axi_bvalid,  // write response valid
  input wire logic s_axi_bready,  // write response ready
  input wire logic [CSS_AW-1:0] s_axi_araddr,  // read address
  input wire logic s_axi_arvalid,  // read address valid
  output logic s_axi_arready,  // read address ready
  output logic [31:0] s_axi_rdata,  // read data
  output logic [1:0] s_axi_rresp,  // read response
  output logic s_axi_rvalid,  // read data valid
  input wire logic s_axi_rready,  // read data ready
  output logic lfCrystalSelect,  // watch crystal drives clock
  output logic rcOscSelect,  // internal RC drives clock
  output logic loadCapEnable,  // internal crystal-pin capacitors
  output logic coreClockEnable,  // clock gate to the core
  output logic [CSS_TRIM_W-1:0] trimValue,  // RC oscillator trim
  output logic [3:0] prescalerInit,  // prescaler select reset value
  output logic startupError  // reserved start-up code seen
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // no reset: the chain must carry fuse and calibration levels while held in reset
  css_async_t asyncIn;
  css_async_t meta_ff;
  css_async_t sync_ff;
  assign asyncIn = '{fuseBlank: fuseArrayBlank, divEight: divideByEightFuse,
                     startup: startupTimeFuses, clockSel: clockSourceSelectFuses,
                     factoryCal: factoryCal, wdtOsc: wdtOscIn, oscCycle: oscCycleIn};

  genvar gi;
  generate
    for (gi = 0; gi < $bits(css_async_t); gi++) begin : g_sync
      always_ff @(posedge clock) begin
        meta_ff[gi] <= asyncIn[gi];
        sync_ff[gi] <= meta_ff[gi];
      end
    end
  endgenerate

  logic wdtPrev_ff;
  logic oscPrev_ff;
  logic wdtTick;
  logic oscTick;
  assign wdtTick = sync_ff.wdtOsc & ~wdtPrev_ff;
  assign oscTick = sync_ff.oscCycle & ~oscPrev_ff;

  // ---------------------------------------------------------------
  // fuse decode
  // ---------------------------------------------------------------
  logic [3:0] effSel;
  logic [1:0] effSut;
  logic effDiv8;
  assign effSel = sync_ff.fuseBlank ? CSS_SEL_DELIVERED : sync_ff.clockSel;
  assign effSut = sync_ff.fuseBlank ? CSS_SUT_DELIVERED : sync_ff.startup;
  assign effDiv8 = sync_ff.fuseBlank ? CSS_DIV8_DELIVERED : sync_ff.divEight;

  logic isLf;
  logic isRc;
  logic capOn;
  logic sutReserved;
  logic srcUnsupported;
  // codes compared as raw bits, one being unprogrammed
  assign isLf = (effSel >= CSS_SEL_LF_LO) && (effSel <= CSS_SEL_LF_HI);
  assign isRc = (effSel == CSS_SEL_RC);
  assign capOn = (effSel == CSS_SEL_CAP_A) || (effSel == CSS_SEL_CAP_B);
  assign sutReserved = (effSut != CSS_SUT_NONE) && (effSut != CSS_SUT_SHORT)
                       && (effSut != CSS_SUT_LONG);
  assign srcUnsupported = ~isLf & ~isRc;

  logic [CSS_CNT_W-1:0] rstTarget;
  logic [CSS_CNT_W-1:0] oscTarget;
  // reset delay counted in watchdog cycles for every source
  assign rstTarget = (effSut == CSS_SUT_NONE) ? '0 :
                     (effSut == CSS_SUT_SHORT) ? CSS_CNT_W'(RST_SHORT_WDT) :
                     CSS_CNT_W'(RST_LONG_WDT);
  // unsupported sources fall back to the shortest count
  assign oscTarget = isLf ? (effSel[0] ? CSS_CNT_W'(LF_LONG_CK)
                                       : CSS_CNT_W'(CSS_LF_SHORT_CK)) :
                     CSS_CNT_W'(CSS_RC_CK);

  // ---------------------------------------------------------------
  // start-up sequencer
  // ---------------------------------------------------------------
  css_state_t state_ff;
  css_state_t nxt_state;
  logic [CSS_CNT_W-1:0] cnt_ff;
  logic [CSS_CNT_W-1:0] nxt_cnt;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      CSS_ST_RESET_DLY: begin
        if (cnt_ff >= rstTarget) begin
          nxt_state = CSS_ST_OSC_START;
          nxt_cnt = '0;
        end else if (wdtTick) begin
          nxt_cnt = cnt_ff + CSS_CNT_W'(1);
        end
      end
      CSS_ST_OSC_START: begin
        if (cnt_ff >= oscTarget) begin
          nxt_state = CSS_ST_RUN;
        end else if (oscTick) begin
          nxt_cnt = cnt_ff + CSS_CNT_W'(1);
        end
      end
      CSS_ST_RUN: begin
        if (sleepRequest) begin
          nxt_state = CSS_ST_SLEEP;
        end
      end
      CSS_ST_SLEEP: begin
        if (wakeRequest) begin
          nxt_state = CSS_ST_OSC_START;
          nxt_cnt = '0;
        end
      end
      default: begin
        nxt_state = CSS_ST_RESET_DLY;
        nxt_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= CSS_ST_RESET_DLY;
      cnt_ff <= '0;
      // held high: a level already high at release must not count as a tick
      wdtPrev_ff <= 1'b1;
      oscPrev_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      wdtPrev_ff <= sync_ff.wdtOsc;
      oscPrev_ff <= sync_ff.oscCycle;
    end
  end

  // ---------------------------------------------------------------
  // decoded outputs
  // ---------------------------------------------------------------
  // registered enable, so the downstream gate never sees a runt pulse
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      coreClockEnable <= 1'b0;
      lfCrystalSelect <= 1'b0;
      rcOscSelect <= 1'b0;
      loadCapEnable <= 1'b0;
      startupError <= 1'b0;
    end else begin
      coreClockEnable <= (nxt_state == CSS_ST_RUN);
      lfCrystalSelect <= isLf;
      rcOscSelect <= isRc;
      loadCapEnable <= capOn;
      startupError <= sutReserved;
    end
  end

  // prescaler reset value is taken while reset is held
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prescalerInit <= (effDiv8 == CSS_FUSE_PROGRAMMED) ? CSS_PRESC_DIV8
                                                        : CSS_PRESC_DIV1;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic awHeld_ff;
  logic wHeld_ff;
  logic [CSS_AW-1:0] awAddr_ff;
  logic [7:0] wByte_ff;
  logic wStrb_ff;
  logic awTake;
  logic wTake;
  logic haveAw;
  logic haveW;
  logic doWrite;
  logic [CSS_AW-1:0] wrAddr;
  logic [7:0] wrByte;
  logic wrStrb;
  logic trimHit;
  logic nxt_awHeld;
  logic nxt_wHeld;
  logic nxt_bvalid;

  assign awTake = s_axi_awvalid & s_axi_awready;
  assign wTake = s_axi_wvalid & s_axi_wready;
  assign haveAw = awHeld_ff | awTake;
  assign haveW = wHeld_ff | wTake;
  assign doWrite = haveAw & haveW & ~s_axi_bvalid;
  assign wrAddr = awHeld_ff ? awAddr_ff : s_axi_awaddr;
  assign wrByte = wHeld_ff ? wByte_ff : s_axi_wdata[7:0];
  assign wrStrb = wHeld_ff ? wStrb_ff : s_axi_wstrb[0];
  assign trimHit = (wrAddr == CSS_TRIM_OFS);
  assign nxt_awHeld = haveAw & ~doWrite;
  assign nxt_wHeld = haveW & ~doWrite;
  assign nxt_bvalid = doWrite | (s_axi_bvalid & ~s_axi_bready);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wByte_ff <= '0;
      wStrb_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CSS_RESP_OKAY;
    end else begin
      awHeld_ff <= nxt_awHeld;
      wHeld_ff <= nxt_wHeld;
      if (awTake) begin
        awAddr_ff <= s_axi_awaddr;
      end
      if (wTake) begin
        wByte_ff <= s_axi_wdata[7:0];
        wStrb_ff <= s_axi_wstrb[0];
      end
      s_axi_awready <= ~nxt_awHeld & ~nxt_bvalid;
      s_axi_wready <= ~nxt_wHeld & ~nxt_bvalid;
      s_axi_bvalid <= nxt_bvalid;
      if (doWrite) begin
        s_axi_bresp <= trimHit ? CSS_RESP_OKAY : CSS_RESP_SLVERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // trim register
  // ---------------------------------------------------------------
  // value drives the RC trim directly: larger code, higher frequency
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trimValue <= sync_ff.factoryCal[CSS_TRIM_W-1:0];
    end else if (doWrite && trimHit && wrStrb) begin
      trimValue <= wrByte[CSS_TRIM_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  css_status_t status;
  logic arTake;
  logic nxt_rvalid;
  logic [31:0] rdMux;
  logic rdHit;

  assign status = '{rsvHi: '0, divEight: effDiv8, startup: effSut, clockSel: effSel,
                    rsvMid: '0, prescInit: prescalerInit, rsvLo: '0,
                    srcUnsupported: srcUnsupported, startupError: startupError,
                    coreClkEn: coreClockEnable, loadCapEn: loadCapEnable,
                    rcSel: rcOscSelect, lfSel: lfCrystalSelect};
  assign arTake = s_axi_arvalid & s_axi_arready;
  assign nxt_rvalid = arTake | (s_axi_rvalid & ~s_axi_rready);
  assign rdHit = (s_axi_araddr == CSS_TRIM_OFS) || (s_axi_araddr == CSS_STATUS_OFS);
  assign rdMux = (s_axi_araddr == CSS_TRIM_OFS) ?
                 {24'h000000, 8'(trimValue) & CSS_TRIM_MASK} :
                 (s_axi_araddr == CSS_STATUS_OFS) ? 32'(status) : 32'h00000000;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= CSS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~nxt_rvalid;
      s_axi_rvalid <= nxt_rvalid;
      if (arTake) begin
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? CSS_RESP_OKAY : CSS_RESP_SLVERR;
      end
    end
  end
endmodule : css_clock_startup

// file: design/css_pkg.sv
/*
  Shared constants and types of the clock source and start-up select block.
  Assumes one 50 MHz system clock and an AXI4-Lite register bus.
*/
package css_pkg;
  // ---------------------------------------------------------------
  // register map and bus
  // ---------------------------------------------------------------
  localparam int CSS_AW = 8;
  localparam logic [CSS_AW-1:0] CSS_TRIM_OFS = 8'h00;
  localparam logic [CSS_AW-1:0] CSS_STATUS_OFS = 8'h04;
  localparam logic [1:0] CSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSS_RESP_SLVERR = 2'h2;
  localparam logic [7:0] CSS_TRIM_MASK = 8'h7F;
  localparam int CSS_TRIM_W = 7;

  // ---------------------------------------------------------------
  // fuse encodings, one means unprogrammed
  // ---------------------------------------------------------------
  localparam logic [3:0] CSS_SEL_RC = 4'h2;
  localparam logic [3:0] CSS_SEL_LF_LO = 4'h4;
  localparam logic [3:0] CSS_SEL_LF_HI = 4'h7;
  localparam logic [3:0] CSS_SEL_CAP_A = 4'h6;
  localparam logic [3:0] CSS_SEL_CAP_B = 4'h7;
  localparam logic [1:0] CSS_SUT_NONE = 2'h0;
  localparam logic [1:0] CSS_SUT_SHORT = 2'h1;
  localparam logic [1:0] CSS_SUT_LONG = 2'h2;
  localparam logic CSS_FUSE_PROGRAMMED = 1'h0;
  localparam logic [3:0] CSS_SEL_DELIVERED = 4'h2;
  localparam logic [1:0] CSS_SUT_DELIVERED = 2'h2;
  localparam logic CSS_DIV8_DELIVERED = 1'h0;
  localparam logic [3:0] CSS_PRESC_DIV8 = 4'h3;
  localparam logic [3:0] CSS_PRESC_DIV1 = 4'h0;

  // ---------------------------------------------------------------
  // start-up timing
  // ---------------------------------------------------------------
  localparam int CSS_CNT_W = 17;
  localparam int CSS_RST_SHORT_US = 4100;  // timed by watchdog oscillator
  localparam int CSS_RST_LONG_US = 65000;
  localparam int CSS_RST_SHORT_WDT = 4096;
  localparam int CSS_RST_LONG_WDT = 65536;
  localparam int CSS_LF_SHORT_CK = 1024;
  localparam int CSS_LF_LONG_CK = 32768;
  localparam int CSS_RC_CK = 6;

  typedef enum logic [1:0] {
    CSS_ST_RESET_DLY,
    CSS_ST_OSC_START,
    CSS_ST_RUN,
    CSS_ST_SLEEP
  } css_state_t;

  typedef struct packed {
    logic fuseBlank;
    logic divEight;
    logic [1:0] startup;
    logic [3:0] clockSel;
    logic [7:0] factoryCal;
    logic wdtOsc;
    logic oscCycle;
  } css_async_t;

  typedef struct packed {
    logic [8:0] rsvHi;
    logic divEight;
    logic [1:0] startup;
    logic [3:0] clockSel;
    logic [3:0] rsvMid;
    logic [3:0] prescInit;
    logic [1:0] rsvLo;
    logic srcUnsupported;
    logic startupError;
    logic coreClkEn;
    logic loadCapEn;
    logic rcSel;
    logic lfSel;
  } css_status_t;
endpackage : css_pkg

// file: dv/clock_source_startup_select_test.sv
/*
  Self-checking bench of the clock source and start-up select block.
  Assumes shortened reset counts and long crystal count; both oscillators toggle every 3 clocks.
*/
`timescale 1ns/1ns
module clock_source_startup_select_test;
  import css_pkg::*;
  logic clock, rst_n, divideByEightFuse, fuseArrayBlank, wdtOscIn, oscCycleIn;
  logic sleepRequest, wakeRequest, lfCrystalSelect, rcOscSelect, loadCapEnable;
  logic coreClockEnable, startupError, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [3:0] clockSourceSelectFuses, s_axi_wstrb, prescalerInit;
  logic [1:0] startupTimeFuses, s_axi_bresp, s_axi_rresp;
  logic [7:0] factoryCal, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [6:0] trimValue;
  int nFail = 0;
  int numChecks = 0;
  int cyc = 0;
  int div = 0;
  // start-up table: source, start-up code, expected oscillator ticks
  logic [3:0] tSel [6] = '{4'h2, 4'h2, 4'h2, 4'h5, 4'h5, 4'h4};
  logic [1:0] tSut [6] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h2, 2'h1};
  int tTick [6] = '{6, 10, 14, 8, 16, 1028};

  css_clock_startup #(.RST_SHORT_WDT(4), .RST_LONG_WDT(8), .LF_LONG_CK(8)) DUT (.*);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ---------------------------------------------------------------
  // oscillators and timeout
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    div <= (div == 2) ? 0 : div + 1;
    if (div == 2) begin
      wdtOscIn <= ~wdtOscIn;
      oscCycleIn <= ~oscCycleIn;
    end
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      nFail = nFail + 1;
      endSim();
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkWin(input int n, input int lo, input int hi);
    numChecks++;
    if (n < lo || n > hi) begin
      nFail++;
      $display("mismatch at %0t: got %h expected %h..%h", $time, n, lo, hi);
    end
  endtask : chkWin
  task automatic endSim();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : endSim
  task automatic doReset(input logic [3:0] sel, input logic [1:0] startup_time_fuses, input logic d8,
                         input logic bl);
    clockSourceSelectFuses <= sel;
    startupTimeFuses <= startup_time_fuses;
    divideByEightFuse <= d8;
    fuseArrayBlank <= bl;
    rst_n <= 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
  endtask : doReset
  // each oscillator tick is six system clocks; allow sync and state slack
  task automatic waitRun(input int t);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (coreClockEnable !== 1'b1 && n < 8000);
    chkWin(n, (t - 1) * 6, t * 6 + 12);
  endtask : waitRun
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, divideByEightFuse, fuseArrayBlank, wdtOscIn, oscCycleIn} = '0;
    {sleepRequest, wakeRequest, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb, s_axi_awaddr, s_axi_araddr} = '0;
    {clockSourceSelectFuses, startupTimeFuses, s_axi_wdata} = '0;
    factoryCal = 8'hA5;
    @(posedge clock);
    doReset(4'h2, 2'h2, 1'b0, 1'b0);
    waitRun(14);
    rd(CSS_TRIM_OFS, 32'h25, CSS_RESP_OKAY);
    rd(CSS_STATUS_OFS, 32'h0022030A, CSS_RESP_OKAY);
    wr(CSS_TRIM_OFS, 32'hFFFFFFFF, 4'hF, CSS_RESP_OKAY);
    rd(CSS_TRIM_OFS, 32'h7F, CSS_RESP_OKAY);
    wr(CSS_TRIM_OFS, 32'h0, 4'h1, CSS_RESP_OKAY);
    wr(CSS_TRIM_OFS, 32'h55, 4'h0, CSS_RESP_OKAY);
    rd(CSS_TRIM_OFS, 32'h0, CSS_RESP_OKAY);
    wr(CSS_STATUS_OFS, 32'h0, 4'hF, CSS_RESP_SLVERR);
    wr(8'h08, 32'h1, 4'hF, CSS_RESP_SLVERR);
    rd(8'h08, 32'h0, CSS_RESP_SLVERR);
    // wake must skip the reset delay, so only the six-cycle count remains
    sleepRequest <= 1'b1;
    @(posedge clock);
    sleepRequest <= 1'b0;
    repeat (10) @(posedge clock);
    chk(32'(coreClockEnable), 32'h0);
    wakeRequest <= 1'b1;
    @(posedge clock);
    wakeRequest <= 1'b0;
    waitRun(6);
    for (int s = 0; s < 16; s++) begin
      clockSourceSelectFuses <= 4'(s);
      repeat (5) @(posedge clock);
      chk({lfCrystalSelect, rcOscSelect, loadCapEnable}, {s[3:2] == 2'h1, s == 2, s[3:1] == 3'h3});
    end
    for (int i = 0; i < 6; i++) begin
      doReset(tSel[i], tSut[i], 1'b1, 1'b0);
      waitRun(tTick[i]);
      chk(32'(prescalerInit), 32'(CSS_PRESC_DIV1));
      chk(32'(startupError), 32'(tSut[i] == 2'h3));
    end
    doReset(4'h5, 2'h0, 1'b1, 1'b1);
    waitRun(14);
    chk({rcOscSelect, prescalerInit}, {1'b1, CSS_PRESC_DIV8});
    endSim();
  end
endmodule : clock_source_startup_select_test

bind css_clock_startup css_clock_startup_chk u_chk (.*);

// file: dv/css_clock_startup_chk.sv
/*
  Port checker of the clock source and start-up select block.
  Assumes fuses and calibration byte stay static across each reset.
*/
`timescale 1ns/1ns
module css_clock_startup_chk
  import css_pkg::*;
(
  input wire logic clock,  // system clock
  input wire logic rst_n,  // sync reset, active low
  input wire logic [3:0] clockSourceSelectFuses,  // source fuses
  input wire logic [1:0] startupTimeFuses,  // start-up fuses
  input wire logic divideByEightFuse,  // zero when programmed
  input wire logic fuseArrayBlank,  // delivered defaults
  input wire logic [7:0] factoryCal,  // calibration byte
  input wire logic sleepRequest,  // sleep entry
  input wire logic [CSS_AW-1:0] s_axi_araddr,  // read address
  input wire logic s_axi_arvalid,  // read address valid
  input wire logic s_axi_arready,  // read address ready
  input wire logic [31:0] s_axi_rdata,  // read data
  input wire logic s_axi_rvalid,  // read data valid
  input wire logic lfCrystalSelect,  // watch crystal chosen
  input wire logic rcOscSelect,  // RC chosen
  input wire logic loadCapEnable,  // pin capacitors
  input wire logic coreClockEnable,  // core clock gate
  input wire logic [CSS_TRIM_W-1:0] trimValue,  // trim
  input wire logic [3:0] prescalerInit,  // prescaler reset value
  input wire logic startupError  // reserved start-up code
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [CSS_AW-1:0] rdAddr_ff;
  always_ff @(posedge clock) if (s_axi_arvalid && s_axi_arready) rdAddr_ff <= s_axi_araddr;
  // three edges of sync and output flop, so four steady samples
  sequence fuseHeld;
    (rst_n && !fuseArrayBlank && $stable(clockSourceSelectFuses) && $stable(startupTimeFuses))[*4];
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_LF_SEL: assert property (fuseHeld |-> lfCrystalSelect == (clockSourceSelectFuses[3:2] == 2'h1))
    else $error("watch crystal select wrong");
  AST_LOAD_CAP: assert property (fuseHeld |-> loadCapEnable == (clockSourceSelectFuses[3:1] == 3'h3))
    else $error("load capacitor enable wrong");
  AST_RC_SEL: assert property (fuseHeld |-> rcOscSelect == (clockSourceSelectFuses == CSS_SEL_RC))
    else $error("rc select wrong");
  AST_SUT_ERR: assert property (fuseHeld |-> startupError == (startupTimeFuses == 2'h3))
    else $error("start-up error flag wrong");
  AST_TRIM_LOAD: assert property ($rose(rst_n) |-> trimValue == factoryCal[6:0])
    else $error("trim not loaded in reset");
  AST_PRESC: assert property ($rose(rst_n) |-> prescalerInit == ((fuseArrayBlank || !divideByEightFuse) ? CSS_PRESC_DIV8 : CSS_PRESC_DIV1))
    else $error("prescaler reset value wrong");
  AST_GATE_RST: assert property ($rose(rst_n) |-> !coreClockEnable)
    else $error("core clock open at reset release");
  AST_TRIM_READ: assert property (s_axi_rvalid && rdAddr_ff == CSS_TRIM_OFS |-> s_axi_rdata == {25'h0, trimValue})
    else $error("trim read data wrong");
  AST_SLEEP_GATE: assert property (sleepRequest && coreClockEnable |=> !coreClockEnable [*8])
    else $error("core clock not gated in sleep");
  COV_RUN: cover property ($rose(coreClockEnable));
  COV_ERR: cover property (startupError);
  COV_CAP: cover property (loadCapEnable);
endmodule : css_clock_startup_chk
